// *** hw/aux_io_pkg.sv ***
package aux_io_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_KHZ        = 200000;
  localparam int unsigned MS_TIME        = 1;
  localparam int unsigned MS_CYCLES_DFLT = CLK_KHZ * MS_TIME;
  localparam int unsigned DB_TIME_NS     = 1000;
  localparam int unsigned DB_CYCLES      = (DB_TIME_NS * CLK_KHZ + 999999) / 1000000;
  localparam int unsigned CNT_W          = 40;
  // ==========================================================
  // register offsets
  localparam logic [7:0] MODE_OFS       = 8'h00;
  localparam logic [7:0] CFG_OFS        = 8'h04;
  localparam logic [7:0] PRE_LEAD_OFS   = 8'h08;
  localparam logic [7:0] PRE_PULSE_OFS  = 8'h0C;
  localparam logic [7:0] POST_DELAY_OFS = 8'h10;
  localparam logic [7:0] POST_PULSE_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS     = 8'h18;
  // ==========================================================
  // fields
  localparam int unsigned CFG_ENDING_BIT = 0;
  localparam int unsigned CFG_HIGH_BIT   = 1;
  localparam int unsigned ST_LINES_LSB   = 0;
  localparam int unsigned ST_RUN_BIT     = 4;
  localparam int unsigned ST_PAUSE_BIT   = 5;
  localparam int unsigned ST_EXT_BIT     = 6;
  localparam int unsigned ST_PRE_BIT     = 7;
  localparam int unsigned ST_POST_BIT    = 8;
  // ==========================================================
  // line function codes
  localparam logic [3:0] FN_NONE   = 4'h0;
  localparam logic [3:0] FN_PAUSE  = 4'h1;
  localparam logic [3:0] FN_HALT   = 4'h2;
  localparam logic [3:0] FN_DIR    = 4'h3;
  localparam logic [3:0] FN_EXTINT = 4'h4;
  localparam logic [3:0] FN_TOGGLE = 4'h5;
  localparam logic [3:0] FN_STOP   = 4'h6;
  localparam logic [3:0] FN_START  = 4'h7;
  localparam logic [3:0] FN_PRE    = 4'h8;
  localparam logic [3:0] FN_POST   = 4'h9;
  // ==========================================================
  // reset values
  localparam logic [15:0] MODE_RST  = 16'h0000;
  localparam logic [15:0] MS_RST    = 16'h0000;
  localparam logic        ENDING_RST = 1'b0;
  localparam logic        HIGH_RST   = 1'b0;
  localparam logic [3:0]  LINES_RST  = 4'hF;
endpackage

// *** hw/aux_io_trigger_actions.sv ***
// Contract
// - three two-way lines, fourth output only
// - lines idle high, asserted when grounded
// - per-line function also picks direction
// - pause trigger pauses or resumes program
// - halt trigger stops motors, camera continues
// - reverse trigger inverts moving motors
// - external interval trigger replaces program interval
// - toggle trigger stops or starts program
// - stop trigger ignored when already stopped
// - start trigger ignored when already running
// - one global edge: falling or rising
// - any line may be pre/post output
// - pre outputs: shared lead and width
// - pre pulses precede focus step
// - post outputs: shared delay and width
// - post pulses after exposure delay ends
// - post pulse once after final repeat
// - one global output polarity
// - external-run status replaces running status
`timescale 1ns/1ps
`default_nettype none
module aux_io_trigger_actions #(
  parameter int unsigned MS_CYCLES = aux_io_pkg::MS_CYCLES_DFLT
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [3:0]  aux_in,
  output logic      [3:0]  aux_out,
  output logic      [3:0]  aux_oe,
  input  wire logic        prog_running,
  input  wire logic        prog_paused,
  input  wire logic        cycle_start,
  input  wire logic        expo_end,
  input  wire logic        last_repeat,
  output logic             focus_go,
  output logic             pause_req,
  output logic             motor_halt,
  output logic             dir_invert,
  output logic             interval_cue,
  output logic             interval_external,
  output logic             prog_start,
  output logic             prog_stop,
  output logic             ext_run
);
  import aux_io_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [3:0][3:0]   mode;
    logic              trig_ending;
    logic              out_high;
    logic [15:0]       pre_exposure_lead_ms;
    logic [15:0]       pre_exposure_pulse_ms;
    logic [15:0]       post_delay_ms;
    logic [15:0]       post_exposure_pulse_ms;
    logic [3:0]        sync1;
    logic [3:0]        sync2;
    logic [3:0]        db;
    logic [3:0][7:0]   db_cnt;
    logic              pre_lead_busy;
    logic              pre_on;
    logic              post_wait;
    logic              post_on;
    logic [CNT_W-1:0]  pre_lead_cnt;
    logic [CNT_W-1:0]  pre_width_cnt;
    logic [CNT_W-1:0]  post_cnt;
    logic              focus_go;
    logic              pause_req;
    logic              motor_halt;
    logic              dir_invert;
    logic              interval_cue;
    logic              prog_start;
    logic              prog_stop;
    logic              ext_active;
    logic              ext_run;
    logic [3:0]        out_val;
    logic [3:0]        out_en;
    logic [31:0]       rdata;
  } state_s;

  state_s st;
  state_s next_st;

  logic [3:0]       is_out;
  logic [3:0]       hit;
  logic [3:0]       active;
  logic [CNT_W-1:0] lead_cyc;
  logic [CNT_W-1:0] pre_w_cyc;
  logic [CNT_W-1:0] post_d_cyc;
  logic [CNT_W-1:0] post_w_cyc;
  logic             halt_hit;
  logic             any_ext;

  assign lead_cyc   = {24'h000000, st.pre_exposure_lead_ms}   * CNT_W'(MS_CYCLES);
  assign pre_w_cyc  = {24'h000000, st.pre_exposure_pulse_ms}  * CNT_W'(MS_CYCLES);
  assign post_d_cyc = {24'h000000, st.post_delay_ms}          * CNT_W'(MS_CYCLES);
  assign post_w_cyc = {24'h000000, st.post_exposure_pulse_ms} * CNT_W'(MS_CYCLES);

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.focus_go     = 1'b0;
    next_st.pause_req    = 1'b0;
    next_st.motor_halt   = 1'b0;
    next_st.dir_invert   = 1'b0;
    next_st.interval_cue = 1'b0;
    next_st.prog_start   = 1'b0;
    next_st.prog_stop    = 1'b0;
    hit      = 4'h0;
    halt_hit = 1'b0;
    any_ext  = 1'b0;

    // register writes; strobes are one cycle, no wait states
    if (reg_wr) begin
      unique case (reg_addr)
        MODE_OFS: begin
          for (int i = 0; i < 4; i++) begin
            next_st.mode[i] = reg_wdata[4*i +: 4];
          end
        end
        CFG_OFS: begin
          next_st.trig_ending = reg_wdata[CFG_ENDING_BIT];
          next_st.out_high    = reg_wdata[CFG_HIGH_BIT];
        end
        PRE_LEAD_OFS:   next_st.pre_exposure_lead_ms   = reg_wdata[15:0];
        PRE_PULSE_OFS:  next_st.pre_exposure_pulse_ms  = reg_wdata[15:0];
        POST_DELAY_OFS: next_st.post_delay_ms          = reg_wdata[15:0];
        POST_PULSE_OFS: next_st.post_exposure_pulse_ms = reg_wdata[15:0];
        default: ;
      endcase
    end

    // line directions; line four never listens
    for (int i = 0; i < 4; i++) begin
      is_out[i] = (st.mode[i] == FN_PRE) || (st.mode[i] == FN_POST);
    end

    // sync then debounce; first stage feeds only the second
    next_st.sync1 = aux_in;
    next_st.sync2 = st.sync1;
    for (int i = 0; i < 3; i++) begin
      if (st.sync2[i] != st.db[i]) begin
        if (st.db_cnt[i] == 8'(DB_CYCLES - 1)) begin
          next_st.db[i]     = st.sync2[i];
          next_st.db_cnt[i] = 8'h00;
          // grounded line reads low: beginning is the falling edge
          hit[i] = !is_out[i] && (st.trig_ending ? st.sync2[i] : !st.sync2[i]);
        end else begin
          next_st.db_cnt[i] = st.db_cnt[i] + 8'h01;
        end
      end else begin
        next_st.db_cnt[i] = 8'h00;
      end
    end
    next_st.db[3]     = 1'b1;
    next_st.db_cnt[3] = 8'h00;

    // input actions
    for (int i = 0; i < 3; i++) begin
      any_ext = any_ext || (st.mode[i] == FN_EXTINT);
      if (hit[i]) begin
        unique case (st.mode[i])
          FN_PAUSE: next_st.pause_req = prog_running || prog_paused;
          FN_HALT: begin
            next_st.motor_halt = 1'b1;
            halt_hit = 1'b1;
          end
          FN_DIR:    next_st.dir_invert   = 1'b1;
          FN_EXTINT: next_st.interval_cue = 1'b1;
          FN_TOGGLE: begin
            next_st.prog_stop  = next_st.prog_stop || prog_running;
            next_st.prog_start = next_st.prog_start || !prog_running;
          end
          FN_STOP:  next_st.prog_stop  = next_st.prog_stop || prog_running;
          FN_START: next_st.prog_start = next_st.prog_start || !prog_running;
          default: ;
        endcase
      end
    end
    // two lines may ask opposite things in one cycle; stop wins
    if (next_st.prog_stop) begin
      next_st.prog_start = 1'b0;
    end
    next_st.ext_active = any_ext;
    next_st.ext_run    = prog_running && any_ext;

    // pre-exposure: outputs go active at cycle start, focus waits out the lead
    if (cycle_start && !st.pre_lead_busy) begin
      next_st.pre_lead_busy = 1'b1;
      next_st.pre_lead_cnt  = lead_cyc;
      next_st.pre_on        = (st.pre_exposure_pulse_ms != 16'h0000);
      next_st.pre_width_cnt = pre_w_cyc;
    end else begin
      if (st.pre_lead_busy) begin
        if (st.pre_lead_cnt <= CNT_W'(1)) begin
          next_st.pre_lead_busy = 1'b0;
          next_st.focus_go      = 1'b1;
        end else begin
          next_st.pre_lead_cnt = st.pre_lead_cnt - CNT_W'(1);
        end
      end
      if (st.pre_on) begin
        if (st.pre_width_cnt <= CNT_W'(1)) begin
          next_st.pre_on = 1'b0;
        end else begin
          next_st.pre_width_cnt = st.pre_width_cnt - CNT_W'(1);
        end
      end
    end

    // post-exposure: only after the final repeat's delay has run out
    if (expo_end && last_repeat && !st.post_wait && !st.post_on) begin
      next_st.post_wait = 1'b1;
      next_st.post_cnt  = post_d_cyc;
    end else if (st.post_wait) begin
      if (st.post_cnt <= CNT_W'(1)) begin
        next_st.post_wait = 1'b0;
        next_st.post_on   = (st.post_exposure_pulse_ms != 16'h0000);
        next_st.post_cnt  = post_w_cyc;
      end else begin
        next_st.post_cnt = st.post_cnt - CNT_W'(1);
      end
    end else if (st.post_on) begin
      if (st.post_cnt <= CNT_W'(1)) begin
        next_st.post_on = 1'b0;
      end else begin
        next_st.post_cnt = st.post_cnt - CNT_W'(1);
      end
    end

    // output pins share one polarity
    for (int i = 0; i < 4; i++) begin
      active[i] = (st.mode[i] == FN_PRE && st.pre_on) || (st.mode[i] == FN_POST && st.post_on);
      next_st.out_en[i]  = is_out[i];
      next_st.out_val[i] = active[i] ? st.out_high : !st.out_high;
    end

    // read data stands the cycle after the strobe only
    next_st.rdata = 32'h00000000;
    if (reg_rd) begin
      unique case (reg_addr)
        MODE_OFS:       next_st.rdata = {16'h0000, st.mode};
        CFG_OFS:        next_st.rdata = {30'h00000000, st.out_high, st.trig_ending};
        PRE_LEAD_OFS:   next_st.rdata = {16'h0000, st.pre_exposure_lead_ms};
        PRE_PULSE_OFS:  next_st.rdata = {16'h0000, st.pre_exposure_pulse_ms};
        POST_DELAY_OFS: next_st.rdata = {16'h0000, st.post_delay_ms};
        POST_PULSE_OFS: next_st.rdata = {16'h0000, st.post_exposure_pulse_ms};
        STATUS_OFS: begin
          next_st.rdata[ST_LINES_LSB +: 4] = st.db;
          next_st.rdata[ST_RUN_BIT]   = prog_running && !st.ext_active;
          next_st.rdata[ST_PAUSE_BIT] = prog_paused;
          next_st.rdata[ST_EXT_BIT]   = st.ext_run;
          next_st.rdata[ST_PRE_BIT]   = st.pre_on;
          next_st.rdata[ST_POST_BIT]  = st.post_on;
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st                        <= '0;
      st.mode                   <= MODE_RST;
      st.trig_ending            <= ENDING_RST;
      st.out_high               <= HIGH_RST;
      st.pre_exposure_lead_ms   <= MS_RST;
      st.pre_exposure_pulse_ms  <= MS_RST;
      st.post_delay_ms          <= MS_RST;
      st.post_exposure_pulse_ms <= MS_RST;
      st.sync1                  <= LINES_RST;
      st.sync2                  <= LINES_RST;
      st.db                     <= LINES_RST;
      st.out_val                <= LINES_RST;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata         = st.rdata;
  assign aux_out           = st.out_val;
  assign aux_oe            = st.out_en;
  assign focus_go          = st.focus_go;
  assign pause_req         = st.pause_req;
  assign motor_halt        = st.motor_halt;
  assign dir_invert        = st.dir_invert;
  assign interval_cue      = st.interval_cue;
  assign interval_external = st.ext_active;
  assign prog_start        = st.prog_start;
  assign prog_stop         = st.prog_stop;
  assign ext_run           = st.ext_run;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_oe_follows_mode: assert property (aux_oe[3] |-> $past(is_out[3]))
    else $error("line four driven while not an output");
  a_halt_cause: assert property (motor_halt |-> $past(halt_hit))
    else $error("motor halt without a halt trigger");
  a_stop_when_run: assert property (prog_stop |-> $past(prog_running))
    else $error("stop issued while already stopped");
  a_start_when_idle: assert property (prog_start |-> !$past(prog_running))
    else $error("start issued while already running");
  a_ext_run_status: assert property (
    ##1 ext_run == $past(prog_running && any_ext))
    else $error("external-run status wrong");
  a_focus_after_lead: assert property (focus_go |-> $past(st.pre_lead_busy))
    else $error("focus issued without pre-exposure lead");
  a_post_last_only: assert property ($rose(st.post_wait) |-> $past(expo_end && last_repeat))
    else $error("post pulse armed without final repeat");
  a_post_after_delay: assert property ($rose(st.post_on) |-> $past(st.post_wait))
    else $error("post pulse began before delay ended");
  a_idle_level: assert property (
    (aux_oe[0] && !st.pre_on && !st.post_on) ##1 (!st.pre_on && !st.post_on)
    |-> aux_out[0] == !$past(st.out_high))
    else $error("inactive output at wrong level");
  // only lines one to three move the debounced value; line four must never act
  a_no_line4_input: assert property (
    (pause_req || motor_halt || dir_invert || interval_cue || prog_start || prog_stop)
    |-> st.db[2:0] != $past(st.db[2:0]))
    else $error("action pulse without an input edge");
  a_pause_needs_prog: assert property (pause_req |-> $past(prog_running || prog_paused))
    else $error("pause request with no program");
  // stop wins a clash so the sequencer never sees both
  a_start_stop_excl: assert property (!(prog_start && prog_stop))
    else $error("start and stop in one cycle");
  a_focus_one_cycle: assert property (focus_go |=> !focus_go)
    else $error("focus pulse longer than one cycle");
endmodule
`default_nettype wire

// *** test/aux_io_trigger_actions_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench
module aux_io_trigger_actions_tb;
  import aux_io_pkg::*;
  localparam int MSC = 10;
  logic        core_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, rd_p = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, seed = 32'h00003A29;
  logic [3:0]  sw_gnd = 4'h0, aux_in, aux_out, aux_oe;
  logic        prog_running = 0, prog_paused = 0, cycle_start = 0, expo_end = 0, last_repeat = 0;
  logic        focus_go, pause_req, motor_halt, dir_invert, interval_cue;
  logic        interval_external, prog_start, prog_stop, ext_run;
  int          err_total = 0, checks_done = 0, lat, wid, foc;
  logic [31:0] rd_q[$];
  logic [5:0]  act_q[$];
  wire logic [5:0] acts = {pause_req, motor_halt, dir_invert, interval_cue, prog_start, prog_stop};

  always #2.5 core_clk = ~core_clk;

  aux_io_trigger_actions #(.MS_CYCLES(MSC)) uut (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .aux_in(aux_in),
    .aux_out(aux_out), .aux_oe(aux_oe), .prog_running(prog_running),
    .prog_paused(prog_paused), .cycle_start(cycle_start), .expo_end(expo_end),
    .last_repeat(last_repeat), .focus_go(focus_go), .pause_req(pause_req),
    .motor_halt(motor_halt), .dir_invert(dir_invert), .interval_cue(interval_cue),
    .interval_external(interval_external), .prog_start(prog_start),
    .prog_stop(prog_stop), .ext_run(ext_run));

  aux_line_model far_side (.sw_gnd(sw_gnd), .drv(aux_out), .oe(aux_oe), .level(aux_in));

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [5:0] exp_act(input logic [3:0] f, input logic run, input logic pau);
    case (f)
      FN_PAUSE:  return (run | pau) ? 6'h20 : 6'h00;
      FN_HALT:   return 6'h10;
      FN_DIR:    return 6'h08;
      FN_EXTINT: return 6'h04;
      FN_TOGGLE: return run ? 6'h01 : 6'h02;
      FN_STOP:   return run ? 6'h01 : 6'h00;
      FN_START:  return run ? 6'h00 : 6'h02;
      default:   return 6'h00;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask

  // close then open a switch; debounce needs 200 cycles, so 230 leaves margin
  task automatic hit(input int ln, input logic [5:0] e_close, input logic [5:0] e_open);
    if (e_close !== 6'h00) act_q.push_back(e_close);
    @(posedge core_clk);
    sw_gnd[ln] <= 1'b1;
    cyc(230);
    if (e_open !== 6'h00) act_q.push_back(e_open);
    sw_gnd[ln] <= 1'b0;
    cyc(230);
  endtask

  task automatic meas(input int ln, input logic lvl);
    lat = 0;
    wid = 0;
    foc = 0;
    for (int k = 1; k < 120; k++) begin
      @(posedge core_clk);
      if (aux_out[ln] === lvl) begin
        if (wid == 0) lat = k;
        wid++;
      end
      if (focus_go === 1'b1) foc = k;
    end
  endtask

  task automatic final_report();
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // watcher: read data one cycle after the strobe, zero otherwise
  always @(posedge core_clk) begin
    if (rst_b) begin
      chk(reg_rdata, rd_p ? (rd_q.size() ? rd_q.pop_front() : 32'hFFFF_FFFF) : 32'h0);
      if (acts !== 6'h00) chk({26'h0, acts}, {26'h0, act_q.size() ? act_q.pop_front() : 6'h00});
    end
    rd_p = reg_rd;
  end

  initial begin
    #300us;
    err_total++;
    final_report();
  end

  // ==========================================================
  // main sequence
  initial begin
    cyc(2);
    rst_b <= 1'b1;
    rd(MODE_OFS, 32'h0);
    rd(CFG_OFS, 32'h0);
    rd(STATUS_OFS, 32'hF);
    rd(8'h1C, 32'h0);
    wr(PRE_LEAD_OFS, 32'h2);
    rd(PRE_LEAD_OFS, 32'h2);
    // every input function twice, program state from the random source
    for (int i = 0; i < 14; i++) begin
      seed = xs(seed);
      @(posedge core_clk);
      prog_running <= seed[0];
      prog_paused <= (i % 7 == 0) & !seed[0] & seed[1];
      wr(MODE_OFS, 32'(i % 7 + 1));
      hit(0, exp_act(4'(i % 7 + 1), seed[0], (i % 7 == 0) & !seed[0] & seed[1]), 6'h00);
    end
    wr(CFG_OFS, 32'h1);
    wr(MODE_OFS, 32'h20);
    hit(1, 6'h00, 6'h10);
    wr(MODE_OFS, 32'h2000);
    hit(3, 6'h00, 6'h00);
    wr(CFG_OFS, 32'h0);
    wr(MODE_OFS, 32'h400);
    @(posedge core_clk);
    prog_running <= 1'b1;
    prog_paused <= 1'b0;
    cyc(3);
    chk({30'h0, interval_external, ext_run}, 32'h3);
    rd(STATUS_OFS, 32'h4F);
    // pre output, active high: lead 2 ms, width 3 ms
    wr(CFG_OFS, 32'h2);
    wr(MODE_OFS, 32'h8);
    wr(PRE_PULSE_OFS, 32'h3);
    cyc(3);
    chk({aux_oe[0], aux_out[0]}, 32'h2);
    cycle_start <= 1'b1;
    @(posedge core_clk);
    cycle_start <= 1'b0;
    meas(0, 1'b1);
    chk(wid, 3 * MSC);
    chk({31'h0, (foc - lat >= 18) && (foc - lat <= 21)}, 32'h1);
    // post output on the output-only line, active low: delay 1 ms, width 2 ms
    wr(CFG_OFS, 32'h0);
    wr(MODE_OFS, 32'h9000);
    wr(POST_DELAY_OFS, 32'h1);
    wr(POST_PULSE_OFS, 32'h2);
    cyc(3);
    for (int r = 0; r < 2; r++) begin
      last_repeat <= r[0];
      expo_end <= 1'b1;
      @(posedge core_clk);
      expo_end <= 1'b0;
      meas(3, 1'b0);
      chk(wid, r * 2 * MSC);
    end
    chk({31'h0, lat >= 11 && lat <= 14}, 32'h1);
    chk(act_q.size(), 0);
    final_report();
  end
endmodule
`default_nettype wire

// *** test/aux_line_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far side: pulled-up lines, switches that close to ground
module aux_line_model (
  input  wire logic [3:0] sw_gnd,
  input  wire logic [3:0] drv,
  input  wire logic [3:0] oe,
  output logic      [3:0] level
);
  // a released line rises through the pull-up, it never keeps the old value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      level[i] = oe[i] ? drv[i] : !sw_gnd[i];
    end
  end
endmodule
`default_nettype wire
